// [hdl/cbc_bus_cycle_control.sv]
// Bus interface and machine cycle control of an 8-bit processor.
// Assumes all inputs synchronous to core_clk; pins are split into
// value, output enable and input; the bench resolves the wires.
`timescale 1ns/1ps
module cbc_bus_cycle_control #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8
) (
  input wire logic core_clk,
  input wire logic reset,
  // Core side
  input wire logic cyc_req,
  input wire logic [2:0] cyc_kind,
  input wire logic [ADDR_W-1:0] cyc_addr,
  input wire logic [DATA_W-1:0] cyc_wdata,
  input wire logic cyc_last,
  input wire logic halt_req,
  output logic cyc_ready,
  output logic cyc_done,
  output logic [DATA_W-1:0] cyc_rdata,
  input wire logic pc_load,
  input wire logic [ADDR_W-1:0] pc_value,
  output logic [ADDR_W-1:0] pc_out,
  input wire logic ei_set,
  input wire logic di_clear,
  input wire logic im_write,
  input wire logic [1:0] im_value,
  input wire logic ivec_write,
  input wire logic [7:0] ivec_value,
  output logic irq_enable_flag,
  output logic svc_valid,
  output logic [1:0] svc_kind,
  output logic [ADDR_W-1:0] svc_data,
  // Processor pins
  output logic [ADDR_W-1:0] addr_out,
  output logic addr_oe,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [DATA_W-1:0] data_in,
  output logic ctrl_oe,
  output logic opcode_fetch_cycle_n,
  output logic memory_request_n,
  output logic io_request_n,
  output logic read_n,
  output logic write_n,
  output logic refresh_cycle_n,
  output logic halt_n,
  output logic bus_grant_out_n,
  input wire logic wait_n,
  input wire logic int_n,
  input wire logic nmi_n,
  input wire logic bus_request_in_n
);
  generate
    if (ADDR_W != 16 || DATA_W != 8) begin : g_bad_width
      $error("cbc_bus_cycle_control serves 16-bit address, 8-bit data");
    end
  endgenerate

  // Automatic wait states per cycle kind
  function automatic logic [1:0] auto_waits(input logic [2:0] k);
    if (k == cbc_pkg::KIND_IO_RD || k == cbc_pkg::KIND_IO_WR) begin
      return cbc_pkg::IO_AUTO_WAITS;
    end else if (k == cbc_pkg::KIND_INTA) begin
      return cbc_pkg::INTA_AUTO_WAITS;
    end
    return cbc_pkg::NO_AUTO_WAITS;
  endfunction : auto_waits

  function automatic logic fetch_like(input logic [2:0] k);
    return k == cbc_pkg::KIND_FETCH || k == cbc_pkg::KIND_INTA;
  endfunction : fetch_like

  cbc_pkg::cbc_state_t state_reg, state_next;
  logic phase_reg, phase_next;
  logic [2:0] kind_reg, kind_next;
  logic [ADDR_W-1:0] addr_hold_reg, addr_hold_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next, rdata_next;
  logic last_reg, last_next, halt_after_reg, halt_after_next;
  logic own_reg, own_next;
  logic [1:0] auto_reg, auto_next, im_reg, im_next;
  logic [ADDR_W-1:0] pc_next;
  logic [cbc_pkg::REFRESH_W-1:0] refresh_cycle_n_reg, refresh_cycle_n_next;
  logic [7:0] ivec_reg, ivec_next;
  logic iff_next, halted_reg, halted_next;
  logic inta_pend_reg, inta_pend_next, nmi_pend_reg, nmi_pend_next;
  logic nmi_prev_reg, nmi_prev_next;
  logic done_next, ready_next, svc_valid_next, finish;
  logic [1:0] svc_kind_next;
  logic [ADDR_W-1:0] svc_data_next;

  // Cycle sequencing, interrupts, halt and bus hand-over
  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    kind_next = kind_reg;
    addr_hold_next = addr_hold_reg;
    wdata_next = wdata_reg;
    rdata_next = cyc_rdata;
    last_next = last_reg;
    halt_after_next = halt_after_reg;
    own_next = own_reg;
    auto_next = auto_reg;
    pc_next = pc_out;
    refresh_cycle_n_next = refresh_cycle_n_reg;
    iff_next = irq_enable_flag;
    im_next = im_reg;
    ivec_next = ivec_reg;
    halted_next = halted_reg;
    inta_pend_next = inta_pend_reg;
    nmi_pend_next = nmi_pend_reg;
    nmi_prev_next = nmi_n;
    done_next = 1'b0;
    svc_valid_next = 1'b0;
    svc_kind_next = svc_kind;
    svc_data_next = svc_data;
    finish = 1'b0;
    // Software controls
    if (ei_set) iff_next = 1'b1;
    if (di_clear) iff_next = 1'b0;
    if (im_write) im_next = im_value;
    if (ivec_write) ivec_next = ivec_value;
    unique case (state_reg)
      cbc_pkg::ST_IDLE: begin
        if (inta_pend_reg) begin
          state_next = cbc_pkg::ST_T1;
          kind_next = cbc_pkg::KIND_INTA;
          addr_hold_next = pc_out;
          own_next = 1'b0;
          inta_pend_next = 1'b0;
        end else if (halted_reg) begin
          state_next = cbc_pkg::ST_T1;
          kind_next = cbc_pkg::KIND_FETCH;
          addr_hold_next = pc_out;
          own_next = 1'b0;
        end else if (cyc_req && cyc_ready) begin
          state_next = cbc_pkg::ST_T1;
          kind_next = cyc_kind;
          addr_hold_next = (cyc_kind == cbc_pkg::KIND_FETCH) ?
                           pc_out : cyc_addr;
          wdata_next = cyc_wdata;
          last_next = cyc_last;
          halt_after_next = halt_req;
          own_next = 1'b1;
        end else if (!bus_request_in_n) begin
          state_next = cbc_pkg::ST_FLOAT;
        end
        phase_next = 1'b0;
      end
      cbc_pkg::ST_T1: begin
        phase_next = ~phase_reg;
        if (phase_reg) begin
          state_next = cbc_pkg::ST_T2;
          auto_next = auto_waits(kind_reg);
        end
      end
      cbc_pkg::ST_T2, cbc_pkg::ST_TW: begin
        phase_next = ~phase_reg;
        if (phase_reg) begin
          if (auto_reg != 2'h0) begin
            state_next = cbc_pkg::ST_TW;
            auto_next = auto_reg - 2'h1;
          end else if (!wait_n) begin
            state_next = cbc_pkg::ST_TW;
          end else begin
            state_next = cbc_pkg::ST_T3;
            if (fetch_like(kind_reg)) rdata_next = data_in;
          end
        end
      end
      cbc_pkg::ST_T3: begin
        phase_next = ~phase_reg;
        if (phase_reg) begin
          if (fetch_like(kind_reg)) begin
            state_next = cbc_pkg::ST_T4;
          end else begin
            finish = 1'b1;
            if (kind_reg == cbc_pkg::KIND_MEM_RD ||
                kind_reg == cbc_pkg::KIND_IO_RD) rdata_next = data_in;
          end
        end
      end
      cbc_pkg::ST_T4: begin
        phase_next = ~phase_reg;
        if (phase_reg) finish = 1'b1;
      end
      cbc_pkg::ST_FLOAT: state_next = cbc_pkg::ST_GRANT;
      cbc_pkg::ST_GRANT: begin
        if (bus_request_in_n) state_next = cbc_pkg::ST_IDLE;
      end
    endcase
    // End of machine cycle
    if (finish) begin
      phase_next = 1'b0;
      state_next = bus_request_in_n ? cbc_pkg::ST_IDLE :
                   cbc_pkg::ST_FLOAT;
      done_next = own_reg;
      if (fetch_like(kind_reg)) refresh_cycle_n_next = refresh_cycle_n_reg + 7'h01;
      if (kind_reg == cbc_pkg::KIND_FETCH && !halted_reg) begin
        pc_next = pc_out + 16'h0001;
      end
      if (kind_reg == cbc_pkg::KIND_INTA) begin
        svc_valid_next = 1'b1;
        if (im_reg == cbc_pkg::IM_2) begin
          svc_kind_next = cbc_pkg::SVC_MODE2;
          svc_data_next = {ivec_reg, cyc_rdata};
        end else if (im_reg == cbc_pkg::IM_1) begin
          svc_kind_next = cbc_pkg::SVC_MODE1;
          svc_data_next = cbc_pkg::MODE1_ADDR;
        end else begin
          svc_kind_next = cbc_pkg::SVC_MODE0;
          svc_data_next = {8'h00, cyc_rdata};
        end
      end else if ((own_reg && last_reg) || halted_reg) begin
        // Instruction boundary: NMI first, then enabled maskable
        if (nmi_pend_reg) begin
          nmi_pend_next = 1'b0;
          iff_next = 1'b0;
          halted_next = 1'b0;
          pc_next = cbc_pkg::NMI_ADDR;
          svc_valid_next = 1'b1;
          svc_kind_next = cbc_pkg::SVC_NMI;
          svc_data_next = cbc_pkg::NMI_ADDR;
        end else if (!int_n && irq_enable_flag) begin
          inta_pend_next = 1'b1;
          iff_next = 1'b0;
          halted_next = 1'b0;
        end else if (own_reg && halt_after_reg) begin
          halted_next = 1'b1;
        end
      end
    end
    if (pc_load) pc_next = pc_value;
    // Falling NMI edge is remembered; set beats clear
    if (nmi_prev_reg && !nmi_n) nmi_pend_next = 1'b1;
    ready_next = state_next == cbc_pkg::ST_IDLE && !halted_next &&
                 !inta_pend_next;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_reg <= cbc_pkg::ST_IDLE;
      phase_reg <= 1'b0;
      kind_reg <= cbc_pkg::KIND_FETCH;
      addr_hold_reg <= cbc_pkg::PC_RESET;
      wdata_reg <= 8'h00;
      cyc_rdata <= 8'h00;
      last_reg <= 1'b0;
      halt_after_reg <= 1'b0;
      own_reg <= 1'b0;
      auto_reg <= cbc_pkg::NO_AUTO_WAITS;
      pc_out <= cbc_pkg::PC_RESET;
      refresh_cycle_n_reg <= cbc_pkg::REFRESH_CYCLE_N_RESET;
      irq_enable_flag <= 1'b0;
      im_reg <= cbc_pkg::IM_0;
      ivec_reg <= cbc_pkg::IVEC_RESET;
      halted_reg <= 1'b0;
      inta_pend_reg <= 1'b0;
      nmi_pend_reg <= 1'b0;
      nmi_prev_reg <= 1'b1;
      cyc_done <= 1'b0;
      cyc_ready <= 1'b0;
      svc_valid <= 1'b0;
      svc_kind <= cbc_pkg::SVC_NMI;
      svc_data <= cbc_pkg::PC_RESET;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      kind_reg <= kind_next;
      addr_hold_reg <= addr_hold_next;
      wdata_reg <= wdata_next;
      cyc_rdata <= rdata_next;
      last_reg <= last_next;
      halt_after_reg <= halt_after_next;
      own_reg <= own_next;
      auto_reg <= auto_next;
      pc_out <= pc_next;
      refresh_cycle_n_reg <= refresh_cycle_n_next;
      irq_enable_flag <= iff_next;
      im_reg <= im_next;
      ivec_reg <= ivec_next;
      halted_reg <= halted_next;
      inta_pend_reg <= inta_pend_next;
      nmi_pend_reg <= nmi_pend_next;
      nmi_prev_reg <= nmi_prev_next;
      cyc_done <= done_next;
      cyc_ready <= ready_next;
      svc_valid <= svc_valid_next;
      svc_kind <= svc_kind_next;
      svc_data <= svc_data_next;
    end
  end

  // Pin values decoded from the coming state, so pins leave flip-flops
  logic [ADDR_W-1:0] addr_pin_next;
  logic addr_oe_next, data_oe_next, ctrl_oe_next, m1_n_next, memory_request_n_n_next;
  logic io_request_n_n_next, rd_n_next, wr_n_next, refresh_cycle_n_n_next;
  always_comb begin
    logic in_cyc, early, mid, wr_k;
    in_cyc = state_next inside {cbc_pkg::ST_T1, cbc_pkg::ST_T2,
      cbc_pkg::ST_TW, cbc_pkg::ST_T3, cbc_pkg::ST_T4};
    early = (state_next == cbc_pkg::ST_T1 && phase_next) ||
            state_next == cbc_pkg::ST_T2 || state_next == cbc_pkg::ST_TW;
    mid = state_next == cbc_pkg::ST_T2 || state_next == cbc_pkg::ST_TW;
    wr_k = kind_next == cbc_pkg::KIND_MEM_WR ||
           kind_next == cbc_pkg::KIND_IO_WR;
    addr_oe_next = in_cyc;
    addr_pin_next = addr_hold_next;
    if (kind_next == cbc_pkg::KIND_FETCH &&
        (state_next == cbc_pkg::ST_T3 || state_next == cbc_pkg::ST_T4)) begin
      addr_pin_next = {ivec_next, 1'b0, refresh_cycle_n_next};
    end
    ctrl_oe_next = !(state_next == cbc_pkg::ST_FLOAT ||
                     state_next == cbc_pkg::ST_GRANT);
    m1_n_next = !(in_cyc && fetch_like(kind_next));
    // Memory request half a state after address; refresh request from mid-T3 to mid-T4, without read strobe
    memory_request_n_n_next = !((kind_next == cbc_pkg::KIND_FETCH && early) ||
      (kind_next == cbc_pkg::KIND_FETCH &&
       ((state_next == cbc_pkg::ST_T3 && phase_next) ||
        (state_next == cbc_pkg::ST_T4 && !phase_next))) ||
      ((kind_next == cbc_pkg::KIND_MEM_RD || kind_next == cbc_pkg::KIND_MEM_WR)
       && (early || state_next == cbc_pkg::ST_T3)));
    io_request_n_n_next = !(((kind_next == cbc_pkg::KIND_IO_RD ||
                      kind_next == cbc_pkg::KIND_IO_WR) &&
                     (mid || state_next == cbc_pkg::ST_T3)) ||
                    (kind_next == cbc_pkg::KIND_INTA &&
                     state_next == cbc_pkg::ST_TW));
    rd_n_next = !((kind_next == cbc_pkg::KIND_FETCH && early) ||
      (kind_next == cbc_pkg::KIND_MEM_RD &&
       (early || state_next == cbc_pkg::ST_T3)) ||
      (kind_next == cbc_pkg::KIND_IO_RD &&
       (mid || state_next == cbc_pkg::ST_T3)));
    wr_n_next = !(wr_k && (mid ||
      (state_next == cbc_pkg::ST_T3 && !phase_next)));
    data_oe_next = wr_k && (early || state_next == cbc_pkg::ST_T3);
    refresh_cycle_n_n_next = !(kind_next == cbc_pkg::KIND_FETCH &&
      (state_next == cbc_pkg::ST_T3 || state_next == cbc_pkg::ST_T4));
  end

  // Pin registers; reset floats buses and idles controls
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      addr_out <= 16'h0000;
      addr_oe <= 1'b0;
      data_out <= 8'h00;
      data_oe <= 1'b0;
      ctrl_oe <= 1'b1;
      opcode_fetch_cycle_n <= 1'b1;
      memory_request_n <= 1'b1;
      io_request_n <= 1'b1;
      read_n <= 1'b1;
      write_n <= 1'b1;
      refresh_cycle_n <= 1'b1;
      halt_n <= 1'b1;
      bus_grant_out_n <= 1'b1;
    end else begin
      addr_out <= addr_pin_next;
      addr_oe <= addr_oe_next;
      data_out <= wdata_next;
      data_oe <= data_oe_next;
      ctrl_oe <= ctrl_oe_next;
      opcode_fetch_cycle_n <= m1_n_next;
      memory_request_n <= memory_request_n_n_next;
      io_request_n <= io_request_n_n_next;
      read_n <= rd_n_next;
      write_n <= wr_n_next;
      refresh_cycle_n <= refresh_cycle_n_n_next;
      halt_n <= !halted_next;
      bus_grant_out_n <= !(state_next == cbc_pkg::ST_GRANT);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  chk_memory_request_n_addr: assert property (!memory_request_n |-> addr_oe)
    else $error("memory request without address");
  chk_wr_data: assert property (!write_n |-> data_oe && addr_oe)
    else $error("write strobe without data");
  chk_grant_float: assert property (!bus_grant_out_n |->
    !addr_oe && !data_oe && !ctrl_oe && $past(!ctrl_oe))
    else $error("grant while pins driven");
  chk_fetch_half: assert property ($fell(opcode_fetch_cycle_n) &&
    kind_reg == cbc_pkg::KIND_FETCH |-> memory_request_n ##1
    !memory_request_n)
    else $error("fetch memory request not half a state late");
  chk_io_autowait: assert property ($fell(io_request_n) &&
    kind_reg != cbc_pkg::KIND_INTA |-> (!io_request_n)[*6])
    else $error("io cycle missing automatic wait");
  chk_inta_waits: assert property ($fell(io_request_n) &&
    kind_reg == cbc_pkg::KIND_INTA |-> (!io_request_n)[*4])
    else $error("acknowledge missing two waits");
  chk_inta_nomreq: assert property (kind_reg == cbc_pkg::KIND_INTA &&
    state_reg != cbc_pkg::ST_IDLE |-> memory_request_n)
    else $error("memory request in acknowledge");
  chk_wait_hold: assert property (state_reg == cbc_pkg::ST_TW && phase_reg &&
    auto_reg == 2'h0 && !wait_n |=> state_reg == cbc_pkg::ST_TW)
    else $error("wait input ignored");
  chk_refresh_t4: assert property (state_reg == cbc_pkg::ST_T4 &&
    kind_reg == cbc_pkg::KIND_FETCH |-> !refresh_cycle_n &&
    addr_out[6:0] == refresh_cycle_n_reg)
    else $error("refresh missing in fourth state");
  chk_nmi_addr: assert property (svc_valid && svc_kind == cbc_pkg::SVC_NMI |->
    svc_data == cbc_pkg::NMI_ADDR && pc_out == cbc_pkg::NMI_ADDR)
    else $error("nmi restart address wrong");
  cov_io_write: cover property (!io_request_n && !write_n);
  cov_grant: cover property (!bus_grant_out_n);
  cov_mode2: cover property (svc_valid && svc_kind == cbc_pkg::SVC_MODE2);
  cov_halted: cover property (!halt_n && !refresh_cycle_n);
endmodule : cbc_bus_cycle_control

// [hdl/cbc_pkg.sv]
// Constants shared by the processor bus cycle controller.
// Assumes one core clock; each bus clock state spans two core clocks.
package cbc_pkg;
  // Machine cycle kinds requested by the core
  localparam logic [2:0] KIND_FETCH = 3'h0;
  localparam logic [2:0] KIND_MEM_RD = 3'h1;
  localparam logic [2:0] KIND_MEM_WR = 3'h2;
  localparam logic [2:0] KIND_IO_RD = 3'h3;
  localparam logic [2:0] KIND_IO_WR = 3'h4;
  localparam logic [2:0] KIND_INTA = 3'h5;
  // Interrupt modes
  localparam logic [1:0] IM_0 = 2'h0;
  localparam logic [1:0] IM_1 = 2'h1;
  localparam logic [1:0] IM_2 = 2'h2;
  // Service notices to the core
  localparam logic [1:0] SVC_NMI = 2'h0;
  localparam logic [1:0] SVC_MODE0 = 2'h1;
  localparam logic [1:0] SVC_MODE1 = 2'h2;
  localparam logic [1:0] SVC_MODE2 = 2'h3;
  // Fixed restart addresses
  localparam logic [15:0] NMI_ADDR = 16'h0066;
  localparam logic [15:0] MODE1_ADDR = 16'h0038;
  // Automatic wait states
  localparam logic [1:0] IO_AUTO_WAITS = 2'h1;
  localparam logic [1:0] INTA_AUTO_WAITS = 2'h2;
  localparam logic [1:0] NO_AUTO_WAITS = 2'h0;
  // Refresh counter width and reset values
  localparam int REFRESH_W = 7;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] IVEC_RESET = 8'h00;
  localparam logic [6:0] REFRESH_CYCLE_N_RESET = 7'h00;
  // Bus controller states
  typedef enum logic [2:0] {
    ST_IDLE, ST_T1, ST_T2, ST_TW, ST_T3, ST_T4, ST_FLOAT, ST_GRANT
  } cbc_state_t;
endpackage : cbc_pkg

// [verification/cbc_bus_partner.sv]
// Memory, I/O ports and interrupting device beside the processor bus.
// Assumes the same core clock; the data wire is resolved here.
`timescale 1ns/1ps
module cbc_bus_partner (
  input wire logic core_clk,
  input wire logic slow,
  input wire logic [7:0] vector,
  input wire logic [15:0] addr_out,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic fetch_n,
  input wire logic mem_n,
  input wire logic io_n,
  input wire logic rd_n,
  input wire logic wr_n,
  output logic [7:0] data_in,
  output logic wait_n
);
  logic [7:0] mem [256];
  logic [7:0] io_mem [256];
  logic [7:0] last_val = 8'h00;
  logic drive;
  logic [7:0] val;
  int wcnt = 0;
  // Answer only under the read strobe, or the vector under acknowledge
  always_comb begin
    drive = (!rd_n && !(mem_n && io_n)) || (!io_n && !fetch_n);
    val = !mem_n ? mem[addr_out[7:0]] : io_mem[addr_out[7:0]];
    if (!io_n && !fetch_n)
      val = vector;
    data_in = data_oe ? data_out : (drive ? val : ~last_val);
  end
  // Store writes; a released wire toggles away from its last value
  always @(posedge core_clk) begin
    last_val <= data_in;
    if (!wr_n && !mem_n)
      mem[addr_out[7:0]] <= data_out;
    if (!wr_n && !io_n)
      io_mem[addr_out[7:0]] <= data_out;
    wcnt <= (mem_n && io_n) ? 0 : wcnt + 1;
  end
  // Slow mode holds wait over the first strobe cycles
  assign wait_n = !(slow && !(mem_n && io_n) && wcnt < 4);
endmodule : cbc_bus_partner

// [verification/cbc_bus_cycle_control_test.sv]
// Self-checking bench for the processor bus cycle controller.
// Assumes the partner model answers reads and stores writes.
`timescale 1ns/1ps
module cbc_bus_cycle_control_test;
  logic core_clk = 0, reset = 1, cyc_req = 0, cyc_last = 0, halt_req = 0;
  logic pc_load = 0, ei_set = 0, di_clear = 0, im_write = 0, ivec_write = 0;
  logic wait_n, int_n = 1, nmi_n = 1, bus_request_in_n = 1, slow = 0;
  logic [2:0] cyc_kind = 3'h0;
  logic [1:0] im_value = 2'h0, svc_kind, svc_k;
  logic [15:0] cyc_addr = 16'h0000, pc_value = 16'h0000, pc_out, svc_data;
  logic [15:0] addr_out, svc_d;
  logic [7:0] cyc_wdata = 8'h00, ivec_value = 8'h12, vector = 8'h34;
  logic [7:0] cyc_rdata, data_out, data_in;
  logic cyc_ready, cyc_done, irq_enable_flag, svc_valid, addr_oe, data_oe;
  logic ctrl_oe, opcode_fetch_cycle_n, memory_request_n, io_request_n;
  logic read_n, write_n, refresh_cycle_n, halt_n, bus_grant_out_n;
  logic [1:0] exp_k [3] = '{2'h1, 2'h2, 2'h3};
  logic [15:0] exp_d [3] = '{16'h0034, 16'h0038, 16'h1234};
  int errors = 0, n_tests = 0, ack_cyc = 0, svc_cnt = 0, s0, a0, lr, lw, ln;
  int i;

  cbc_bus_cycle_control u_dut (.*);
  cbc_bus_partner u_bus (.core_clk(core_clk), .slow(slow), .vector(vector),
    .addr_out(addr_out), .data_out(data_out), .data_oe(data_oe),
    .fetch_n(opcode_fetch_cycle_n), .mem_n(memory_request_n),
    .io_n(io_request_n), .rd_n(read_n), .wr_n(write_n),
    .data_in(data_in), .wait_n(wait_n));

  always #20 core_clk = ~core_clk;

  // Record service notices and the acknowledge length
  always @(posedge core_clk) begin
    if (svc_valid === 1'b1) begin
      svc_cnt <= svc_cnt + 1;
      svc_k <= svc_kind;
      svc_d <= svc_data;
    end
    if (!io_request_n && !opcode_fetch_cycle_n)
      ack_cyc <= ack_cyc + 1;
    if (ctrl_oe && !io_request_n && !memory_request_n)
      check(0, "memory strobe with io strobe");
  end

  task automatic step();
    @(posedge core_clk);
    #1;
  endtask : step

  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      errors++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic results();
    $display("Comparisons %0d, errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  // Bounded wait for a level
  task automatic wait_for(ref logic s, input logic v, input int lim);
    for (int k = 0; s !== v; k++) begin
      if (k == lim) begin
        check(0, "timeout");
        results();
      end
      step();
    end
  endtask : wait_for

  // Bounded wait for a further service notice
  task automatic wait_svc(input int n0, input int lim);
    for (int k = 0; svc_cnt == n0; k++) begin
      if (k == lim) begin
        check(0, "timeout");
        results();
      end
      step();
    end
  endtask : wait_svc

  // One machine cycle, watching the pins until done
  task automatic run(input logic [2:0] k, input logic [15:0] a,
      input logic [7:0] wd, input logic last, output int len);
    logic bad, fe, mr, io, rf;
    logic [15:0] ea;
    wait_for(cyc_ready, 1'b1, 60);
    ea = (k == cbc_pkg::KIND_FETCH) ? pc_out : a;
    {bad, fe, mr, io, rf} = 5'h00;
    cyc_req = 1;
    cyc_kind = k;
    cyc_addr = a;
    cyc_wdata = wd;
    cyc_last = last;
    step();
    cyc_req = 0;
    for (len = 0; cyc_done !== 1'b1; len++) begin
      if (len == 60) begin
        check(0, "timeout");
        results();
      end
      fe |= !opcode_fetch_cycle_n;
      mr |= !memory_request_n;
      io |= !io_request_n;
      rf |= !refresh_cycle_n;
      if (!write_n && (data_oe !== 1'b1 || data_out !== wd))
        bad = 1;
      if (!memory_request_n && refresh_cycle_n && addr_out !== ea)
        bad = 1;
      if (!io_request_n && addr_out[7:0] !== ea[7:0])
        bad = 1;
      if (len == 0 && (addr_out !== ea || memory_request_n !== 1'b1))
        bad = 1;
      if (len == 1 && k < cbc_pkg::KIND_IO_RD && memory_request_n !== 1'b0)
        bad = 1;
      step();
    end
    check(!bad, "strobe against bus");
    check(fe === (k == cbc_pkg::KIND_FETCH), "fetch strobe");
    check(rf === (k == cbc_pkg::KIND_FETCH), "refresh strobe");
    check(io === (k >= cbc_pkg::KIND_IO_RD), "io strobe");
    check(mr === (k < cbc_pkg::KIND_IO_RD), "memory strobe");
  endtask : run

  initial begin
    repeat (15) step();
    check({addr_oe, data_oe, cyc_ready} === 3'h0, "float in reset");
    check(&{opcode_fetch_cycle_n, memory_request_n, io_request_n, read_n,
      write_n, refresh_cycle_n, halt_n, bus_grant_out_n}, "idle");
    step();
    reset = 0;
    check(pc_out === 16'h0000 && !irq_enable_flag, "reset values");
    run(cbc_pkg::KIND_MEM_WR, 16'h1234, 8'h5a, 0, lw);
    run(cbc_pkg::KIND_MEM_RD, 16'h1234, 8'h00, 0, lr);
    check(cyc_rdata === 8'h5a && lw == lr, "memory data");
    run(cbc_pkg::KIND_IO_WR, 16'h0042, 8'ha5, 0, ln);
    run(cbc_pkg::KIND_IO_RD, 16'h0042, 8'h00, 0, ln);
    check(cyc_rdata === 8'ha5 && ln == lr + 2, "io cycle");
    $display("test memory and io done");
    slow = 1;
    run(cbc_pkg::KIND_MEM_RD, 16'h1234, 8'h00, 0, ln);
    check(cyc_rdata === 8'h5a && ln > lr, "memory wait");
    run(cbc_pkg::KIND_IO_RD, 16'h0042, 8'h00, 0, ln);
    check(cyc_rdata === 8'ha5 && ln > lr + 2, "io wait");
    slow = 0;
    $display("test wait done");
    pc_value = 16'h1234;
    pc_load = 1;
    step();
    pc_load = 0;
    run(cbc_pkg::KIND_FETCH, 16'h0000, 8'h00, 0, ln);
    check(cyc_rdata === 8'h5a && pc_out === 16'h1235, "fetch");
    check(ln == lr + 2, "fetch length");
    ei_set = 1;
    step();
    check(irq_enable_flag === 1'b1, "enable set");
    {ei_set, di_clear} = 2'h1;
    step();
    di_clear = 0;
    check(irq_enable_flag === 1'b0, "enable cleared");
    int_n = 0;
    run(cbc_pkg::KIND_FETCH, 16'h0000, 8'h00, 1, ln);
    repeat (20) step();
    check(svc_cnt == 0, "masked request");
    ivec_write = 1;
    step();
    ivec_write = 0;
    // Every interrupt mode in turn
    for (i = 0; i < 3; i++) begin
      int_n = 1;
      im_value = i[1:0];
      im_write = 1;
      ei_set = 1;
      step();
      {im_write, ei_set, int_n} = 3'h0;
      s0 = svc_cnt;
      a0 = ack_cyc;
      run(cbc_pkg::KIND_FETCH, 16'h0000, 8'h00, 1, ln);
      wait_svc(s0, 40);
      check(svc_k === exp_k[i] && svc_d === exp_d[i], "vector");
      check(ack_cyc - a0 == 4 && !irq_enable_flag, "acknowledge");
    end
    int_n = 1;
    $display("test interrupt modes done");
    ei_set = 1;
    step();
    {ei_set, int_n, nmi_n} = 3'h0;
    s0 = svc_cnt;
    run(cbc_pkg::KIND_FETCH, 16'h0000, 8'h00, 1, ln);
    wait_svc(s0, 40);
    int_n = 1;
    check(svc_k === 2'h0 && svc_d === 16'h0066, "nmi first");
    check(pc_out === 16'h0066, "nmi restart");
    nmi_n = 1;
    wait_for(cyc_ready, 1'b1, 60);
    {halt_req, cyc_req, cyc_last} = 3'h7;
    cyc_kind = cbc_pkg::KIND_FETCH;
    step();
    {halt_req, cyc_req} = 2'h0;
    wait_for(halt_n, 1'b0, 60);
    wait_for(refresh_cycle_n, 1'b0, 60);
    s0 = svc_cnt;
    nmi_n = 0;
    wait_svc(s0, 80);
    wait_for(halt_n, 1'b1, 40);
    check(svc_k === 2'h0 && halt_n === 1'b1, "halt exit");
    nmi_n = 1;
    $display("test nmi and halt done");
    bus_request_in_n = 0;
    wait_for(bus_grant_out_n, 1'b0, 40);
    check({addr_oe, data_oe, ctrl_oe} === 3'h0, "float at grant");
    bus_request_in_n = 1;
    wait_for(bus_grant_out_n, 1'b1, 40);
    run(cbc_pkg::KIND_MEM_RD, 16'h1234, 8'h00, 0, ln);
    check(cyc_rdata === 8'h5a, "after grant");
    $display("test bus grant done");
    results();
  end
endmodule : cbc_bus_cycle_control_test
